// ### verilog/tbpf_chb_pin.sv
/*
 * Channel B pin function of a timer channel: output waveform selection,
 * compare-match pin actions and input capture edge selection.
 * Assumes the counter, comparators and waveform generators sit outside,
 * all inputs synchronous to clk_i, and a plain 8-bit register port.
 */
// Notes on behaviour
// - pin function field meaning depends on the selected operating mode
// - pwm/single-pulse: 00 forces inactive, 01 forces active
// - pwm/single-pulse: 10 routes pwm wave, 11 routes single-pulse wave
// - capture: 00 rising, 01 falling, 10 both edges latch the counter
// - capture: 11 disables capture entirely
// - compare: initial-level bit sets pin before the first match
// - pwm/single-pulse: initial-level bit picks active high or active low
// - polarity bit inverts the pin; no effect in capture or timer/counter mode
`timescale 1ns/1ns
`include "tbpf_regs.svh"

module tbpf_chb_pin #(
    parameter int CNT_W = 10
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // register port
    input wire logic [2:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // timer core
    input wire logic [CNT_W-1:0] counter_i,
    input wire logic cmp_a_match_i,
    input wire logic pwm_wave_i,
    input wire logic single_pulse_wave_i,
    // channel b pin
    input wire logic channel_b_pin_i,
    output logic channel_b_pin_o,
    output logic channel_b_pin_oe_o,
    // capture result
    output logic cap_valid_o,
    output logic [CNT_W-1:0] cap_value_o
);

    // capture high byte holds at most eight bits
    if (CNT_W < 9 || CNT_W > 16) begin : g_cnt_w_check
        $error("tbpf_chb_pin: CNT_W must lie in 9..16");
    end

    typedef struct packed {
        tbpf_pkg::tbpf_ctrl_type ctrl;
        logic cmp_level;
        logic seen;
        logic cap_flag;
        logic cap_valid;
        logic [CNT_W-1:0] cap;
        logic pin;
        logic oe;
        logic [7:0] rdata;
    } tbpf_state_type;

    tbpf_state_type state_r;
    tbpf_state_type state_nxt;
    tbpf_pkg::tbpf_bus_req_type req;
    logic rise;
    logic fall;
    logic ctrl_wr;
    logic cap_hit;
    logic [15:0] cap_wide;

    // capture edge selection by pin function code
    function automatic logic edge_hit(input logic [1:0] func,
                                      input logic r, input logic f);
        unique case (func)
            `TBPF_FN_00: edge_hit = r;
            `TBPF_FN_01: edge_hit = f;
            `TBPF_FN_10: edge_hit = r | f;
            `TBPF_FN_11: edge_hit = 1'b0;
        endcase
    endfunction

    // pin level after a compare match A
    function automatic logic match_level(input logic [1:0] func,
                                         input logic cur);
        unique case (func)
            `TBPF_FN_00: match_level = cur;
            `TBPF_FN_01: match_level = 1'b0;
            `TBPF_FN_10: match_level = 1'b1;
            `TBPF_FN_11: match_level = ~cur;
        endcase
    endfunction

    // pin input edges
    tbpf_edge_det u_edge (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .level_i(channel_b_pin_i),
        .rise_o(rise),
        .fall_o(fall)
    );

    // bundle the register port
    assign req.addr = reg_addr_i;
    assign req.wdata = reg_wdata_i;
    assign req.wr = reg_wr_i;
    assign req.rd = reg_rd_i;
    assign ctrl_wr = req.wr && req.addr == `TBPF_OFF_CTRL;
    assign cap_hit = state_r.ctrl.mode == tbpf_pkg::TBPF_MODE_CAP &&
                     edge_hit(state_r.ctrl.func, rise, fall);
    assign cap_wide = 16'(state_r.cap);

    // next state: register file, compare level, capture, pin drive
    always_comb begin
        logic cur;
        logic raw;
        cur = 1'b0;
        raw = 1'b0;
        state_nxt = state_r;
        state_nxt.cap_valid = 1'b0;

        // compare level: before first match the initial bit rules
        cur = state_r.seen ? state_r.cmp_level
                           : state_r.ctrl.init_level;
        if (state_r.ctrl.mode == tbpf_pkg::TBPF_MODE_CMP &&
                cmp_a_match_i && state_r.ctrl.func != `TBPF_FN_00) begin
            state_nxt.cmp_level = match_level(state_r.ctrl.func, cur);
            state_nxt.seen = 1'b1;
        end

        // capture latches the counter, flag set wins over read clear
        if (req.rd && req.addr == `TBPF_OFF_STAT) begin
            state_nxt.cap_flag = 1'b0;
        end
        if (cap_hit) begin
            state_nxt.cap = counter_i;
            state_nxt.cap_valid = 1'b1;
            state_nxt.cap_flag = 1'b1;
        end

        // a control write restarts the initial-level phase
        if (ctrl_wr) begin
            state_nxt.ctrl.mode = tbpf_pkg::tbpf_mode_type'(
                req.wdata[`TBPF_MODE_HI:`TBPF_MODE_LO]);
            state_nxt.ctrl.func = req.wdata[`TBPF_FUNC_HI:`TBPF_FUNC_LO];
            state_nxt.ctrl.init_level = req.wdata[`TBPF_INIT_BIT];
            state_nxt.ctrl.polarity = req.wdata[`TBPF_POL_BIT];
            state_nxt.ctrl.spare = req.wdata[1:0];
            state_nxt.seen = 1'b0;
        end

        // pin drive follows the new configuration at once
        unique case (state_nxt.ctrl.mode)
            tbpf_pkg::TBPF_MODE_CMP: begin
                raw = state_nxt.seen ? state_nxt.cmp_level
                                     : state_nxt.ctrl.init_level;
                state_nxt.oe = 1'b1;
            end
            tbpf_pkg::TBPF_MODE_PWM: begin
                // init bit is the active level
                unique case (state_nxt.ctrl.func)
                    `TBPF_FN_00: raw = ~state_nxt.ctrl.init_level;
                    `TBPF_FN_01: raw = state_nxt.ctrl.init_level;
                    `TBPF_FN_10: raw = ~(pwm_wave_i ^
                        state_nxt.ctrl.init_level);
                    `TBPF_FN_11: raw = ~(single_pulse_wave_i ^
                        state_nxt.ctrl.init_level);
                endcase
                state_nxt.oe = 1'b1;
            end
            tbpf_pkg::TBPF_MODE_CAP, tbpf_pkg::TBPF_MODE_TMR: begin
                // capture listens, timer/counter leaves the pin alone
                raw = 1'b0;
                state_nxt.oe = 1'b0;
            end
        endcase
        state_nxt.pin = state_nxt.oe &
                        (raw ^ state_nxt.ctrl.polarity);

        // read data, unmapped offsets read zero
        state_nxt.rdata = 8'h00;
        if (req.rd) begin
            unique case (req.addr)
                `TBPF_OFF_CTRL: state_nxt.rdata = state_r.ctrl;
                `TBPF_OFF_STAT: begin
                    state_nxt.rdata[`TBPF_ST_PIN] = state_r.pin;
                    state_nxt.rdata[`TBPF_ST_OE] = state_r.oe;
                    state_nxt.rdata[`TBPF_ST_SEEN] = state_r.seen;
                    state_nxt.rdata[`TBPF_ST_CAP] = state_r.cap_flag;
                end
                `TBPF_OFF_CAPL: state_nxt.rdata = cap_wide[7:0];
                `TBPF_OFF_CAPH: state_nxt.rdata = cap_wide[15:8];
                default: state_nxt.rdata = 8'h00;
            endcase
        end
    end

    // single state register
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state_r.ctrl <= `TBPF_CTRL_RESET;
            state_r.cmp_level <= 1'b0;
            state_r.seen <= 1'b0;
            state_r.cap_flag <= 1'b0;
            state_r.cap_valid <= 1'b0;
            state_r.cap <= CNT_W'(`TBPF_CAP_RESET);
            state_r.pin <= 1'b0;
            state_r.oe <= 1'b1;
            state_r.rdata <= 8'h00;
        end else begin
            state_r <= state_nxt;
        end
    end

    // outputs straight from flops
    assign reg_rdata_o = state_r.rdata;
    assign channel_b_pin_o = state_r.pin;
    assign channel_b_pin_oe_o = state_r.oe;
    assign cap_valid_o = state_r.cap_valid;
    assign cap_value_o = state_r.cap;

    // capture and timer/counter modes never drive the pin
    property p_no_drive;
        @(posedge clk_i) disable iff (!reset_n_i)
        state_r.ctrl.mode inside {tbpf_pkg::TBPF_MODE_CAP,
                                  tbpf_pkg::TBPF_MODE_TMR}
        |-> !channel_b_pin_oe_o && !channel_b_pin_o;
    endproperty
    a_no_drive: assert property (p_no_drive)
        else $error("pin driven in capture or timer mode");

    // forced levels in pwm mode
    property p_force;
        @(posedge clk_i) disable iff (!reset_n_i)
        state_r.ctrl.mode == tbpf_pkg::TBPF_MODE_PWM &&
        state_r.ctrl.func[1] == 1'b0
        |-> channel_b_pin_o == (~(state_r.ctrl.func[0] ^
            state_r.ctrl.init_level) ^ state_r.ctrl.polarity);
    endproperty
    a_force: assert property (p_force)
        else $error("forced pwm level wrong");

    // pwm waveform one cycle later on the pin
    property p_pwm_wave;
        @(posedge clk_i) disable iff (!reset_n_i)
        $past(reset_n_i) && state_r.ctrl.mode == tbpf_pkg::TBPF_MODE_PWM &&
        state_r.ctrl.func == `TBPF_FN_10
        |-> channel_b_pin_o == (~($past(pwm_wave_i) ^
            state_r.ctrl.init_level) ^ state_r.ctrl.polarity);
    endproperty
    a_pwm_wave: assert property (p_pwm_wave)
        else $error("pwm wave not routed to pin");

    // single pulse waveform one cycle later on the pin
    property p_sp_wave;
        @(posedge clk_i) disable iff (!reset_n_i)
        $past(reset_n_i) && state_r.ctrl.mode == tbpf_pkg::TBPF_MODE_PWM &&
        state_r.ctrl.func == `TBPF_FN_11
        |-> channel_b_pin_o == (~($past(single_pulse_wave_i) ^
            state_r.ctrl.init_level) ^ state_r.ctrl.polarity);
    endproperty
    a_sp_wave: assert property (p_sp_wave)
        else $error("single pulse wave not routed to pin");

    // rising edge capture
    property p_cap_rise;
        @(posedge clk_i) disable iff (!reset_n_i)
        state_r.ctrl.mode == tbpf_pkg::TBPF_MODE_CAP &&
        state_r.ctrl.func == `TBPF_FN_00 && rise
        |=> cap_valid_o && cap_value_o == $past(counter_i);
    endproperty
    a_cap_rise: assert property (p_cap_rise)
        else $error("rising edge capture missed");

    // falling edge captures under falling-only selection
    property p_cap_fall;
        @(posedge clk_i) disable iff (!reset_n_i)
        state_r.ctrl.mode == tbpf_pkg::TBPF_MODE_CAP &&
        state_r.ctrl.func == `TBPF_FN_01 && fall
        |=> cap_valid_o && cap_value_o == $past(counter_i);
    endproperty
    a_cap_fall: assert property (p_cap_fall)
        else $error("falling edge capture wrong");

    // either edge captures under both-edge selection
    property p_cap_both;
        @(posedge clk_i) disable iff (!reset_n_i)
        state_r.ctrl.mode == tbpf_pkg::TBPF_MODE_CAP &&
        state_r.ctrl.func == `TBPF_FN_10 && (rise || fall)
        |=> cap_valid_o && cap_value_o == $past(counter_i);
    endproperty
    a_cap_both: assert property (p_cap_both)
        else $error("either-edge capture missed");

    // disabled capture stays silent
    property p_cap_off;
        @(posedge clk_i) disable iff (!reset_n_i)
        state_r.ctrl.mode == tbpf_pkg::TBPF_MODE_CAP &&
        state_r.ctrl.func == `TBPF_FN_11 |=> !cap_valid_o;
    endproperty
    a_cap_off: assert property (p_cap_off)
        else $error("capture while disabled");

    // toggle on compare match
    property p_toggle;
        @(posedge clk_i) disable iff (!reset_n_i)
        state_r.ctrl.mode == tbpf_pkg::TBPF_MODE_CMP &&
        state_r.ctrl.func == `TBPF_FN_11 && cmp_a_match_i && !ctrl_wr
        |=> channel_b_pin_o == !$past(channel_b_pin_o);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("pin did not toggle on match");

    // initial level with polarity after a control write
    property p_initial;
        @(posedge clk_i) disable iff (!reset_n_i)
        ctrl_wr && reg_wdata_i[`TBPF_MODE_HI:`TBPF_MODE_LO] == 2'h0
        |=> channel_b_pin_o == ($past(reg_wdata_i[`TBPF_INIT_BIT]) ^
            $past(reg_wdata_i[`TBPF_POL_BIT]));
    endproperty
    a_initial: assert property (p_initial)
        else $error("initial compare level wrong");

endmodule // tbpf_chb_pin

// ### verilog/tbpf_regs.svh
/*
 * Register offsets, field positions, reset values and pin-function codes of
 * the channel B pin function block.
 * Assumes an 8-bit plain register port with a 3-bit address.
 */
`ifndef TBPF_REGS_SVH
`define TBPF_REGS_SVH

// register offsets
`define TBPF_OFF_CTRL 3'h0
`define TBPF_OFF_STAT 3'h1
`define TBPF_OFF_CAPL 3'h2
`define TBPF_OFF_CAPH 3'h3

// control register field positions
`define TBPF_MODE_HI 7
`define TBPF_MODE_LO 6
`define TBPF_FUNC_HI 5
`define TBPF_FUNC_LO 4
`define TBPF_INIT_BIT 3
`define TBPF_POL_BIT 2

// status register field positions
`define TBPF_ST_PIN 0
`define TBPF_ST_OE 1
`define TBPF_ST_SEEN 2
`define TBPF_ST_CAP 3

// reset values
`define TBPF_CTRL_RESET 8'h00
`define TBPF_CAP_RESET 16'h0000

// two-bit pin function codes
`define TBPF_FN_00 2'h0
`define TBPF_FN_01 2'h1
`define TBPF_FN_10 2'h2
`define TBPF_FN_11 2'h3

`endif

// ### verilog/tbpf_pkg.sv
/*
 * Types shared by the channel B pin function block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tbpf_pkg;

    // operating mode of the channel, two-bit select
    typedef enum logic [1:0] {
        TBPF_MODE_CMP = 2'h0,
        TBPF_MODE_CAP = 2'h1,
        TBPF_MODE_PWM = 2'h2,
        TBPF_MODE_TMR = 2'h3
    } tbpf_mode_type;

    // control byte as software sees it
    typedef struct packed {
        tbpf_mode_type mode;
        logic [1:0] func;
        logic init_level;
        logic polarity;
        logic [1:0] spare;
    } tbpf_ctrl_type;

    // one request on the register port
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tbpf_bus_req_type;

endpackage

// ### verilog/tbpf_edge_det.sv
/*
 * Edge detector for the channel B pin input.
 * Assumes the pin input is already synchronous to clk_i.
 */
`timescale 1ns/1ns

module tbpf_edge_det (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // sampled level
    input wire logic level_i,
    // edge pulses, one cycle each
    output logic rise_o,
    output logic fall_o
);

    typedef struct packed {
        logic prev;
    } tbpf_edge_state_type;

    tbpf_edge_state_type state_r;
    tbpf_edge_state_type state_nxt;

    // remember last level
    always_comb begin
        state_nxt = state_r;
        state_nxt.prev = level_i;
    end

    // reset to low so a pin high at release counts as a rising edge
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign rise_o = level_i & ~state_r.prev;
    assign fall_o = ~level_i & state_r.prev;

endmodule // tbpf_edge_det

// ### dv/tbpf_pin_model.sv
/*
 * Far side of the channel B pin: a signal source that also loads the pin.
 * Assumes the bench sets the source level by non-blocking assignment.
 */
`timescale 1ns/1ns

module tbpf_pin_model (
    // block side of the pin
    input wire logic pin_o_i,
    input wire logic oe_i,
    // level the source drives while the block listens
    input wire logic src_level_i,
    // resolved wire level
    output logic pin_level_o
);
    // the source is weak: a driving block always wins the wire
    assign pin_level_o = oe_i ? pin_o_i : src_level_i;
endmodule // tbpf_pin_model

// ### dv/tb.sv
/*
 * Self-checking bench for the channel B pin function block.
 * Assumes the register header and package from verilog/ are compiled first.
 */
`timescale 1ns/1ns
`include "tbpf_regs.svh"

module tb;
    // stimulus
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [2:0] reg_addr_i = 3'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [9:0] counter_i = 10'h000;
    logic cmp_a_match_i = 1'b0;
    logic pwm_wave_i = 1'b0;
    logic single_pulse_wave_i = 1'b0;
    logic src_level = 1'b0;
    // observed
    logic pin_level;
    logic [7:0] reg_rdata_o;
    logic channel_b_pin_o;
    logic channel_b_pin_oe_o;
    logic cap_valid_o;
    logic [9:0] cap_value_o;
    int failures = 0;
    int checks = 0;
    int caps = 0;
    logic [7:0] rv;
    logic [9:0] exp_cap;
    logic b1;
    logic b2;
    logic act;
    int n0;

    always #50 clk_i = ~clk_i;

    tbpf_chb_pin #(.CNT_W(10)) dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .counter_i(counter_i),
        .cmp_a_match_i(cmp_a_match_i), .pwm_wave_i(pwm_wave_i),
        .single_pulse_wave_i(single_pulse_wave_i),
        .channel_b_pin_i(pin_level), .channel_b_pin_o(channel_b_pin_o),
        .channel_b_pin_oe_o(channel_b_pin_oe_o),
        .cap_valid_o(cap_valid_o), .cap_value_o(cap_value_o)
    );

    tbpf_pin_model pin_model (
        .pin_o_i(channel_b_pin_o), .oe_i(channel_b_pin_oe_o),
        .src_level_i(src_level), .pin_level_o(pin_level)
    );

    // capture pulses stand one cycle; mid-cycle sampling avoids the launch edge
    always @(negedge clk_i) begin
        if (cap_valid_o === 1'b1) begin
            caps <= caps + 1;
        end
    end

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_i);
        d = reg_rdata_o;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    task automatic pulse_match();
        @(posedge clk_i);
        cmp_a_match_i <= 1'b1;
        @(posedge clk_i);
        cmp_a_match_i <= 1'b0;
        @(negedge clk_i);
    endtask

    function automatic logic [7:0] mk(input logic [1:0] m,
        input logic [1:0] f, input logic i, input logic p);
        return {m, f, i, p, 2'h0};
    endfunction

    task automatic check_pin(input logic oe, input logic lvl);
        check("pin_oe", 16'(channel_b_pin_oe_o), 16'(oe));
        check("pin_level", 16'(channel_b_pin_o), 16'(lvl));
    endtask

    // a hung run still reaches the verdict
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        complete_run();
    end

    initial begin
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        settle(0);
        check_pin(1'b1, 1'b0);
        rd(`TBPF_OFF_CTRL, rv);
        check("ctrl_reset", 16'(rv), 16'(`TBPF_CTRL_RESET));
        wr(3'h5, 8'hFF);
        rd(3'h5, rv);
        check("unmapped", 16'(rv), 16'h0000);
        $display("test reset done");

        // capture edge selection, source drives the pin
        exp_cap = 10'h000;
        for (int f = 0; f < 4; f++) begin
            wr(`TBPF_OFF_CTRL, mk(tbpf_pkg::TBPF_MODE_CAP, 2'(f), 1'b1, 1'b1));
            settle(0);
            check_pin(1'b0, 1'b0);
            n0 = caps;
            @(posedge clk_i);
            counter_i <= 10'h1A5;
            src_level <= 1'b1;
            settle(3);
            b1 = (f == 0 || f == 2);
            if (b1) begin
                exp_cap = 10'h1A5;
            end
            check("rise_caps", 16'(caps - n0), 16'(b1));
            check("rise_value", 16'(cap_value_o), 16'(exp_cap));
            if (f == 0) begin
                rd(`TBPF_OFF_STAT, rv);
                check("cap_flag", 16'(rv[`TBPF_ST_CAP]), 16'h0001);
                rd(`TBPF_OFF_STAT, rv);
                check("cap_flag_clr", 16'(rv[`TBPF_ST_CAP]), 16'h0000);
            end
            n0 = caps;
            @(posedge clk_i);
            counter_i <= 10'h05A;
            src_level <= 1'b0;
            settle(3);
            b1 = (f == 1 || f == 2);
            if (b1) begin
                exp_cap = 10'h05A;
            end
            check("fall_caps", 16'(caps - n0), 16'(b1));
            check("fall_value", 16'(cap_value_o), 16'(exp_cap));
            rd(`TBPF_OFF_CAPL, rv);
            check("cap_low", 16'(rv), 16'(exp_cap[7:0]));
            rd(`TBPF_OFF_CAPH, rv);
            check("cap_high", 16'(rv), 16'(exp_cap[9:8]));
        end
        $display("test capture done");

        // waveform routing, active level and polarity
        for (int k = 0; k < 32; k++) begin
            @(posedge clk_i);
            pwm_wave_i <= k[4];
            single_pulse_wave_i <= ~k[4];
            wr(`TBPF_OFF_CTRL,
               mk(tbpf_pkg::TBPF_MODE_PWM, k[1:0], k[2], k[3]));
            settle(0);
            act = (k[1:0] == 2'h0) ? 1'b0 : (k[1:0] == 2'h1) ? 1'b1 :
                  (k[1:0] == 2'h2) ? k[4] : ~k[4];
            b1 = (act ? k[2] : ~k[2]) ^ k[3];
            check_pin(1'b1, b1);
            rd(`TBPF_OFF_STAT, rv);
            check("stat_pin", 16'(rv[1:0]), 16'({1'b1, b1}));
        end
        $display("test waveform done");

        // compare-match pin actions from each initial level
        for (int k = 0; k < 16; k++) begin
            wr(`TBPF_OFF_CTRL,
               mk(tbpf_pkg::TBPF_MODE_CMP, k[1:0], k[2], k[3]));
            settle(0);
            check_pin(1'b1, k[2] ^ k[3]);
            b1 = (k[1:0] == 2'h0) ? k[2] : (k[1:0] == 2'h1) ? 1'b0 :
                 (k[1:0] == 2'h2) ? 1'b1 : ~k[2];
            b2 = (k[1:0] == 2'h3) ? ~b1 : b1;
            pulse_match();
            check_pin(1'b1, b1 ^ k[3]);
            rd(`TBPF_OFF_STAT, rv);
            check("seen", 16'(rv[`TBPF_ST_SEEN]), 16'(k[1:0] != 0));
            pulse_match();
            check_pin(1'b1, b2 ^ k[3]);
        end
        $display("test compare done");

        // timer mode leaves the pin undriven even with func 01 (force active), init and polarity set
        wr(`TBPF_OFF_CTRL, mk(tbpf_pkg::TBPF_MODE_TMR, 2'h1, 1'b1, 1'b1));
        settle(1);
        check_pin(1'b0, 1'b0);
        rd(`TBPF_OFF_CTRL, rv);
        check("ctrl_rw", 16'(rv), 16'hDC);
        $display("test timer done");
        complete_run();
    end
endmodule // tb
